// ===== hw/lci_pkg.sv
package lci_pkg;

    // =====================================================================
    // Register map (word aligned, AHB-Lite byte addresses)
    // =====================================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COND = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_LAMP = 8'h0c;
    localparam logic [7:0] ADDR_FLASH = 8'h10;

    // =====================================================================
    // Field positions
    // =====================================================================
    // CTRL
    localparam int CTRL_ENABLE = 0;
    // COND: condition inputs written by the supervisory firmware
    localparam int COND_POWER_LOW = 0;
    localparam int COND_CTRL_FAULT = 1;
    localparam int COND_FIELD_FAULT = 2;
    localparam int COND_INTERRUPTED = 3;
    localparam int COND_MISALIGNED = 4;
    localparam int COND_CONTAMINATED = 5;
    localparam int COND_SHORT = 6;
    localparam int COND_W = 7;
    // STAT
    localparam int STAT_STARTED = 0;
    localparam int STAT_SAFE_ON = 1;
    localparam int STAT_TEST = 2;
    localparam int STAT_STATE_LSB = 4;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [COND_W-1:0] COND_RESET = 7'h00;

    // =====================================================================
    // Timing at 250 MHz
    // =====================================================================
    localparam int CLK_MHZ = 250;
    localparam int FLASH_HALF_MS = 250;
    localparam int SHORT_PERIOD_S = 3;
    localparam int SHORT_PULSE_MS = 100;
    localparam int STARTUP_MS = 2000;
    localparam int IRREG_SLOTS = 8;
    // One millisecond tick feeds all slow timers
    localparam int MS_CYCLES = CLK_MHZ * 1000;
    localparam int SHORT_PERIOD_MS = SHORT_PERIOD_S * 1000;
    // Irregular flashing pattern over eight half-periods
    localparam logic [IRREG_SLOTS-1:0] IRREG_PATTERN = 8'h35;

    // =====================================================================
    // Indicator modes and unit state
    // =====================================================================
    typedef enum logic [2:0] {
        LCI_OFF,
        LCI_ON,
        LCI_FLASH,
        LCI_IRREG,
        LCI_SHORT_PULSE
    } lci_lamp_e;

    typedef enum logic [2:0] {
        LCI_ST_STARTUP,
        LCI_ST_RUN,
        LCI_ST_TEST,
        LCI_ST_STOP,
        LCI_ST_FAULT
    } lci_state_e;

endpackage

// ===== hw/lci_blink.sv
`timescale 1ns/100ps
`default_nettype none

// Free-running flash timebase shared by every indicator of both units
module lci_blink #(
    parameter int MS_CYCLES = lci_pkg::MS_CYCLES,
    parameter int HALF_MS = lci_pkg::FLASH_HALF_MS,
    parameter int PERIOD_MS = lci_pkg::SHORT_PERIOD_MS,
    parameter int PULSE_MS = lci_pkg::SHORT_PULSE_MS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Timebase outputs
    output logic ms_tick,
    output logic flash,
    output logic irreg,
    output logic short_pulse
);

    logic [31:0] div_r;
    logic [15:0] half_r;
    logic [15:0] per_r;
    logic [2:0] slot_r;
    logic flash_r;

    assign ms_tick = (div_r == 32'(MS_CYCLES - 1));

    // =====================================================================
    // Millisecond divider
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 32'h0000_0000;
        end else if (clk_en) begin
            div_r <= ms_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
        end
    end

    // =====================================================================
    // Regular flash and irregular pattern slot
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_r <= 16'h0000;
            flash_r <= 1'b0;
            slot_r <= 3'h0;
        end else if (clk_en && ms_tick) begin
            if (half_r == 16'(HALF_MS - 1)) begin
                half_r <= 16'h0000;
                flash_r <= ~flash_r;
                slot_r <= slot_r + 3'h1;
            end else begin
                half_r <= half_r + 16'h0001;
            end
        end
    end

    // =====================================================================
    // Short pulse once per period
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_r <= 16'h0000;
        end else if (clk_en && ms_tick) begin
            per_r <= (per_r == 16'(PERIOD_MS - 1)) ? 16'h0000 : per_r + 16'h0001;
        end
    end

    assign flash = flash_r;
    // Uneven on/off runs so it cannot be mistaken for the regular flash
    assign irreg = lci_pkg::IRREG_PATTERN[slot_r];
    assign short_pulse = (per_r < 16'(PULSE_MS));

endmodule
`default_nettype wire

// ===== hw/lci_top.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Test closed: tx power on, ok on
// - Test open: tx test lamp, rx outputs off
// - Controller fault: red steady, power flashes
// - Field fault: power and red flash
// - Field free, outputs on: power, green and red lit
// - Interrupted or misaligned: outputs off, flash power
// - Output short: power pulse every 3 s
// - Low supply: only power lamp lit
// - Cover contamination turns safety outputs off
// - Start-up complete within 2 s
module lci_top #(
    parameter int MS_CYCLES = lci_pkg::MS_CYCLES,
    parameter int STARTUP_MS = lci_pkg::STARTUP_MS,
    parameter int HALF_MS = lci_pkg::FLASH_HALF_MS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Transmitter test contact, high while closed
    input wire logic test_closed,
    // Safety outputs
    output logic safety_switch_output_a,
    output logic safety_switch_output_b,
    // Transmitter indicators
    output logic tx_power_led,
    output logic tx_ok_led,
    output logic tx_test_led,
    // Receiver indicators
    output logic rx_power_led,
    output logic rx_green_led,
    output logic rx_red_led
);

    // =====================================================================
    // Declarations
    // =====================================================================
    logic ms_tick;
    logic flash;
    logic irreg;
    logic short_pulse;
    logic [31:0] ctrl_r;
    logic [lci_pkg::COND_W-1:0] cond_r;
    logic [15:0] start_cnt_r;
    logic started_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_nxt;
    logic safe_on_r;
    lci_pkg::lci_state_e state_r;
    lci_pkg::lci_state_e state_nxt;
    lci_pkg::lci_lamp_e txp, txo, txt, rxp, rxg, rxr;
    logic [5:0] leds_r;
    logic [5:0] leds_nxt;
    logic enable;
    logic stop_cond;
    logic any_fault;

    // =====================================================================
    // Flash timebase
    // =====================================================================
    lci_blink #(
        .MS_CYCLES(MS_CYCLES),
        .HALF_MS(HALF_MS),
        .PERIOD_MS(lci_pkg::SHORT_PERIOD_MS),
        .PULSE_MS(lci_pkg::SHORT_PULSE_MS)
    ) u_blink (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .ms_tick(ms_tick),
        .flash(flash),
        .irreg(irreg),
        .short_pulse(short_pulse)
    );

    // Map an indicator mode onto a lamp level for this cycle
    function automatic logic lamp(input lci_pkg::lci_lamp_e m, input logic f, input logic i,
                                  input logic s);
        case (m)
            lci_pkg::LCI_ON: lamp = 1'b1;
            lci_pkg::LCI_FLASH: lamp = f;
            lci_pkg::LCI_IRREG: lamp = i;
            lci_pkg::LCI_SHORT_PULSE: lamp = s;
            default: lamp = 1'b0;
        endcase
    endfunction

    // =====================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    // =====================================================================
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (clk_en && hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    // Registers are written in the data phase from hwdata
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= lci_pkg::CTRL_RESET;
            cond_r <= lci_pkg::COND_RESET;
        end else if (clk_en && wr_pend_r) begin
            case (wr_addr_r)
                lci_pkg::ADDR_CTRL: ctrl_r <= {31'h0, hwdata[lci_pkg::CTRL_ENABLE]};
                lci_pkg::ADDR_COND: cond_r <= hwdata[lci_pkg::COND_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (haddr[7:0])
            lci_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
            lci_pkg::ADDR_COND: rdata_nxt = {25'h0, cond_r};
            lci_pkg::ADDR_STAT: rdata_nxt = {25'h0, 3'(state_r), 1'b0, ~test_closed, safe_on_r, started_r};
            lci_pkg::ADDR_LAMP: rdata_nxt = {26'h0, leds_r};
            lci_pkg::ADDR_FLASH: rdata_nxt = {29'h0, short_pulse, irreg, flash};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data latched at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // =====================================================================
    // Start-up timer
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_cnt_r <= 16'h0000;
            started_r <= 1'b0;
        end else if (clk_en && ms_tick && !started_r) begin
            // Start-up never stretches past the limit, done at its last ms
            if (start_cnt_r == 16'(STARTUP_MS - 1)) begin
                started_r <= 1'b1;
            end else begin
                start_cnt_r <= start_cnt_r + 16'h0001;
            end
        end
    end

    // =====================================================================
    // Unit state
    // =====================================================================
    assign enable = ctrl_r[lci_pkg::CTRL_ENABLE];
    assign any_fault = cond_r[lci_pkg::COND_CTRL_FAULT] | cond_r[lci_pkg::COND_FIELD_FAULT];
    // Contamination reads as a blocked beam
    assign stop_cond = cond_r[lci_pkg::COND_INTERRUPTED] | cond_r[lci_pkg::COND_MISALIGNED]
                     | cond_r[lci_pkg::COND_CONTAMINATED] | cond_r[lci_pkg::COND_SHORT];

    always_comb begin
        if (any_fault) begin
            state_nxt = lci_pkg::LCI_ST_FAULT;
        end else if (!started_r || cond_r[lci_pkg::COND_POWER_LOW] || !enable) begin
            state_nxt = lci_pkg::LCI_ST_STARTUP;
        end else if (!test_closed) begin
            state_nxt = lci_pkg::LCI_ST_TEST;
        end else if (stop_cond) begin
            state_nxt = lci_pkg::LCI_ST_STOP;
        end else begin
            state_nxt = lci_pkg::LCI_ST_RUN;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= lci_pkg::LCI_ST_STARTUP;
            safe_on_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            // Outputs only on in the run state: test, stop, fault all drop them
            safe_on_r <= (state_nxt == lci_pkg::LCI_ST_RUN);
        end
    end

    assign safety_switch_output_a = safe_on_r;
    assign safety_switch_output_b = safe_on_r;

    // =====================================================================
    // Indicator modes
    // =====================================================================
    always_comb begin
        txp = lci_pkg::LCI_ON;
        txo = lci_pkg::LCI_OFF;
        txt = lci_pkg::LCI_OFF;
        rxp = lci_pkg::LCI_ON;
        rxg = lci_pkg::LCI_OFF;
        rxr = lci_pkg::LCI_OFF;
        if (cond_r[lci_pkg::COND_CTRL_FAULT]) begin
            txp = lci_pkg::LCI_FLASH;
            txt = lci_pkg::LCI_ON;
            rxp = lci_pkg::LCI_IRREG;
            rxr = lci_pkg::LCI_ON;
        end else if (cond_r[lci_pkg::COND_FIELD_FAULT]) begin
            txp = lci_pkg::LCI_FLASH;
            txt = lci_pkg::LCI_FLASH;
            rxp = lci_pkg::LCI_FLASH;
            rxr = lci_pkg::LCI_FLASH;
        end else if (cond_r[lci_pkg::COND_POWER_LOW] || !started_r || !enable) begin
            // Only power lit on both units until supply and start-up are good
            txo = lci_pkg::LCI_OFF;
        end else begin
            if (test_closed) begin
                txo = lci_pkg::LCI_ON;
            end else begin
                txt = lci_pkg::LCI_ON;
            end
            if (cond_r[lci_pkg::COND_SHORT]) begin
                rxp = lci_pkg::LCI_SHORT_PULSE;
                rxr = lci_pkg::LCI_FLASH;
            end else if (state_nxt == lci_pkg::LCI_ST_RUN) begin
                rxg = lci_pkg::LCI_ON;
                rxr = lci_pkg::LCI_ON;
            end else begin
                rxp = lci_pkg::LCI_FLASH;
                rxr = lci_pkg::LCI_ON;
            end
        end
    end

    always_comb begin
        leds_nxt[0] = lamp(txp, flash, irreg, short_pulse);
        leds_nxt[1] = lamp(txo, flash, irreg, short_pulse);
        leds_nxt[2] = lamp(txt, flash, irreg, short_pulse);
        leds_nxt[3] = lamp(rxp, flash, irreg, short_pulse);
        leds_nxt[4] = lamp(rxg, flash, irreg, short_pulse);
        leds_nxt[5] = lamp(rxr, flash, irreg, short_pulse);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            leds_r <= 6'h00;
        end else if (clk_en) begin
            leds_r <= leds_nxt;
        end
    end

    assign tx_power_led = leds_r[0];
    assign tx_ok_led = leds_r[1];
    assign tx_test_led = leds_r[2];
    assign rx_power_led = leds_r[3];
    assign rx_green_led = leds_r[4];
    assign rx_red_led = leds_r[5];

endmodule
`default_nettype wire

// ===== bench/lci_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Port checker for the indicator block
// =====================================================================
module lci_top_chk #(
    parameter int MS_CYCLES = 4,
    parameter int STARTUP_MS = 5,
    parameter int HALF_MS = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Contact and outputs
    input wire logic test_closed,
    input wire logic safety_switch_output_a,
    input wire logic safety_switch_output_b,
    // Indicators
    input wire logic tx_power_led,
    input wire logic tx_ok_led,
    input wire logic tx_test_led,
    input wire logic rx_power_led,
    input wire logic rx_green_led,
    input wire logic rx_red_led
);
    // Cycles since reset release, saturating at the end of start-up
    int unsigned up_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_cnt <= 0;
        end else if (up_cnt < STARTUP_MS * MS_CYCLES) begin
            up_cnt <= up_cnt + 1;
        end
    end

    bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp) else $error("bus answer not zero-wait OKAY");
    outputs_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
        safety_switch_output_a == safety_switch_output_b) else $error("safety outputs disagree");
    test_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !test_closed |=> !safety_switch_output_a && !tx_ok_led) else $error("open test left output on");
    tx_ok_lamps_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_ok_led |-> tx_power_led && !tx_test_led) else $error("tx ok lamp with wrong companions");
    run_lamps_a: assert property (@(posedge hclk) disable iff (!hresetn)
        safety_switch_output_a |-> rx_power_led && rx_green_led && rx_red_led) else $error("run lamps wrong");
    green_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_green_led |-> rx_power_led) else $error("green lit without steady power");
    safe_test_a: assert property (@(posedge hclk) disable iff (!hresetn)
        safety_switch_output_a |-> $past(test_closed) && tx_ok_led) else $error("output on without test closed");
    // Slack of one cycle allows for the registered outputs trailing the timer
    startup_dark_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (up_cnt >= 1 && up_cnt < STARTUP_MS * MS_CYCLES - 1) |-> tx_power_led && rx_power_led
        && !tx_ok_led && !tx_test_led && !rx_green_led && !rx_red_led && !safety_switch_output_a)
        else $error("start-up lamps wrong");
endmodule

bind lci_top lci_top_chk #(.MS_CYCLES(MS_CYCLES), .STARTUP_MS(STARTUP_MS), .HALF_MS(HALF_MS)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .test_closed(test_closed),
    .safety_switch_output_a(safety_switch_output_a), .safety_switch_output_b(safety_switch_output_b),
    .tx_power_led(tx_power_led), .tx_ok_led(tx_ok_led), .tx_test_led(tx_test_led),
    .rx_power_led(rx_power_led), .rx_green_led(rx_green_led), .rx_red_led(rx_red_led)
);

`default_nettype wire

// ===== bench/lci_relay.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Test contact and safety relay on the far side
// =====================================================================
module lci_relay (
    // Clock
    input wire logic hclk,
    // Test request from the bench
    input wire logic open_req,
    // Safety outputs
    input wire logic out_a,
    input wire logic out_b,
    // Contact and relay state
    output logic test_closed,
    output logic relay_on
);
    logic closed_r = 1'b1;
    // Jumpered contact stays closed; opening it asks for a test
    always @(posedge hclk) begin
        closed_r <= !open_req;
    end
    assign test_closed = closed_r;
    // Relay pulls in only when both channels agree, so one stuck channel cannot arm it
    assign relay_on = out_a & out_b;
endmodule

`default_nettype wire

// ===== bench/lci_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module lci_top_tb;
    localparam int MS = 4;
    localparam int SU = 5;
    localparam int HM = 2;
    localparam int FL = HM * MS;
    localparam int WS = 4 * SU * MS;
    localparam int LIMIT = 40000;
    // =================================================================
    // Signals
    // =================================================================
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic open_req = 1'b0;
    logic [31:0] hrdata;
    logic hresp, test_closed, ssa, ssb, relay_on;
    wire hready;
    wire [5:0] leds;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    lci_top #(.MS_CYCLES(MS), .STARTUP_MS(SU), .HALF_MS(HM)) DUT (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .test_closed(test_closed), .safety_switch_output_a(ssa),
        .safety_switch_output_b(ssb), .tx_power_led(leds[0]), .tx_ok_led(leds[1]), .tx_test_led(leds[2]),
        .rx_power_led(leds[3]), .rx_green_led(leds[4]), .rx_red_led(leds[5])
    );
    lci_relay u_relay (.hclk(hclk), .open_req(open_req), .out_a(ssa), .out_b(ssb),
        .test_closed(test_closed), .relay_on(relay_on));

    initial begin
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total = err_total + 1;
            end_sim();
        end
    end
    // =================================================================
    // Shared tasks
    // =================================================================
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Single word transfer; waits on hready with no assumed latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(w, x, e);
    endtask
    task automatic wait_safe();
        int n;
        n = 0;
        while (ssa !== 1'b1 && n < WS) begin
            @(posedge hclk);
            n++;
        end
    endtask
    // Classes per lamp: 0 dark, 1 steady, 2 flashing; longest lit runs of both power lamps
    task automatic observe(output logic [11:0] cls, output int rxrun, output int txrun);
        logic [5:0] s1, s0;
        int rc, tc;
        s1 = '0;
        s0 = '0;
        rc = 0;
        tc = 0;
        rxrun = 0;
        txrun = 0;
        repeat (96) begin
            @(posedge hclk);
            s1 |= leds;
            s0 |= ~leds;
            rc = leds[3] ? rc + 1 : 0;
            tc = leds[0] ? tc + 1 : 0;
            rxrun = (rc > rxrun) ? rc : rxrun;
            txrun = (tc > txrun) ? tc : txrun;
        end
        for (int j = 0; j < 6; j++) begin
            cls[2*j+:2] = (s1[j] && s0[j]) ? 2'h2 : {1'b0, s1[j]};
        end
    endtask
    // =================================================================
    // Scenarios
    // =================================================================
    task automatic t_startup();
        repeat (3) @(posedge hclk);
        chk("startup lamps", 32'(leds), 32'h09);
        rd_chk("ctrl reset", lci_pkg::ADDR_CTRL, lci_pkg::CTRL_RESET);
        rd_chk("cond reset", lci_pkg::ADDR_COND, 32'h0);
        wait_safe();
        chk("started", 32'(ssa), 32'h1);
    endtask
    task automatic t_run();
        chk("run lamps", 32'(leds), 32'h3b);
        chk("relay", 32'(relay_on), 32'h1);
        rd_chk("stat run", lci_pkg::ADDR_STAT, 32'h13);
        rd_chk("lamp reg", lci_pkg::ADDR_LAMP, 32'h3b);
        wr(8'h14, 32'hffff_ffff);
        rd_chk("unmapped", 8'h14, 32'h0);
        wr(lci_pkg::ADDR_STAT, 32'h0);
        rd_chk("stat ro", lci_pkg::ADDR_STAT, 32'h13);
        wr(lci_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge hclk);
        chk("disabled", 32'(ssa), 32'h0);
        wr(lci_pkg::ADDR_CTRL, 32'h1);
        wait_safe();
    endtask
    task automatic t_test();
        open_req <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("test output", 32'(ssa), 32'h0);
        chk("test tx lamps", 32'(leds[2:0]), 32'h5);
        rd_chk("stat test", lci_pkg::ADDR_STAT, 32'h25);
        open_req <= 1'b0;
        wait_safe();
        chk("test restart", 32'(ssa), 32'h1);
    endtask
    task automatic t_conditions();
        logic [11:0] exp [7] = '{12'h07f, 12'h492, 12'h8a2, 12'h485, 12'h485, 12'hfc5, 12'h8c5};
        int rxr [7] = '{0, 2 * FL, FL, FL, FL, 0, 0};
        int txr [7] = '{0, FL, FL, 0, 0, 0, 0};
        logic [11:0] cls;
        int rr, tr;
        for (int i = 0; i < 7; i++) begin
            wr(lci_pkg::ADDR_COND, 32'h1 << i);
            repeat (4) @(posedge hclk);
            chk($sformatf("cond %0d output", i), 32'(ssa), 32'h0);
            observe(cls, rr, tr);
            for (int j = 0; j < 6; j++) begin
                if (exp[i][2*j+:2] != 2'h3) begin
                    chk($sformatf("cond %0d lamp %0d", i, j), 32'(cls[2*j+:2]), 32'(exp[i][2*j+:2]));
                end
            end
            if (rxr[i] > 0) begin
                chk($sformatf("cond %0d rx run", i), 32'(rr), 32'(rxr[i]));
            end
            if (txr[i] > 0) begin
                chk($sformatf("cond %0d tx run", i), 32'(tr), 32'(txr[i]));
            end
            wr(lci_pkg::ADDR_COND, 32'h0);
            wait_safe();
        end
    endtask
    task automatic t_short();
        int hi, per;
        hi = 0;
        wr(lci_pkg::ADDR_COND, 32'h40);
        while (leds[3] !== 1'b0) @(posedge hclk);
        while (leds[3] !== 1'b1) @(posedge hclk);
        while (leds[3] === 1'b1) begin
            @(posedge hclk);
            hi++;
        end
        per = hi;
        while (leds[3] !== 1'b1) begin
            @(posedge hclk);
            per++;
        end
        chk("pulse width", 32'(hi), 32'(100 * MS));
        chk("pulse period", 32'(per), 32'(3000 * MS));
        wr(lci_pkg::ADDR_COND, 32'h0);
        wait_safe();
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        chk("reset lamps", 32'(leds), 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        t_startup();
        t_run();
        t_test();
        t_conditions();
        t_short();
        end_sim();
    end
endmodule

`default_nettype wire
